// ==== include/acc_pkg.sv ====
// constants for the analog comparator control block
// assumes a 32-bit AHB-Lite slave port, one word per register
package acc_pkg;
    // register indices and byte addresses (index times four)
    localparam logic [7:0] IDX_CTRL = 8'h00;
    localparam logic [7:0] IDX_MUX = 8'h02;
    localparam logic [7:0] IDX_IE = 8'h06;
    localparam logic [7:0] IDX_STAT = 8'h07;
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADDR_MUX = {IDX_MUX[5:0], 2'b00};
    localparam logic [7:0] ADDR_IE = {IDX_IE[5:0], 2'b00};
    localparam logic [7:0] ADDR_STAT = {IDX_STAT[5:0], 2'b00};
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [1:0] RST_NEG = 2'h0;
    localparam logic RST_INV = 1'b0;
    localparam logic RST_IE = 1'b0;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_STATE = 1'b0;
    // comparator_control fields
    localparam int CTRL_RUNSTBY_BIT = 7;
    localparam int CTRL_PINOE_BIT = 6;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_LP_BIT = 3;
    localparam int CTRL_HYS_LSB = 1;
    localparam int CTRL_EN_BIT = 0;
    // input_select fields
    localparam int MUX_INV_BIT = 7;
    localparam int MUX_NEG_LSB = 0;
    // interrupt_enable and comparator_status fields
    localparam int IE_BIT = 0;
    localparam int STAT_STATE_BIT = 4;
    localparam int STAT_FLAG_BIT = 0;
    // edge_mode encodings
    localparam logic [1:0] MODE_ANY = 2'h0;
    localparam logic [1:0] MODE_RSVD = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;
    // negative_input_select encodings
    localparam logic [1:0] NEG_PIN = 2'h0;
    localparam logic [1:0] NEG_RSVD = 2'h1;
    localparam logic [1:0] NEG_VREF = 2'h2;
    localparam logic [1:0] NEG_DAC = 2'h3;
    localparam logic POS_PIN = 1'b0;
    // sleep mode codes from the power controller
    localparam logic [1:0] SLP_ACTIVE = 2'h0;
    localparam logic [1:0] SLP_IDLE = 2'h1;
    localparam logic [1:0] SLP_STBY = 2'h2;
    localparam logic [1:0] SLP_PDOWN = 2'h3;
    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int HTRANS_ACT_BIT = 1;
    typedef enum logic [1:0] {
        ACC_BUS_IDLE = 2'b00,
        ACC_BUS_WR = 2'b01,
        ACC_BUS_RDW = 2'b10,
        ACC_BUS_RDD = 2'b11
    } acc_bus_e;
endpackage : acc_pkg

// ==== design/acc_sync.sv ====
// two-flop synchroniser for the asynchronous comparator result
// assumes a single peripheral clock and async active-high reset
`timescale 1ns/1ps
module acc_sync (
    input wire logic clk_in, // peripheral clock
    input wire logic rst_in, // async reset, active high
    input wire logic d_in, // asynchronous level
    output logic q_out // synchronised level
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d_in;
            sync_q <= meta_q;
        end
    end

    assign q_out = sync_q;
endmodule : acc_sync

// ==== design/acc_edge.sv ====
// edge detector for the comparator level with selectable edge
// assumes a synchronised input level on the same clock
`timescale 1ns/1ps
module acc_edge (
    input wire logic clk_in, // peripheral clock
    input wire logic rst_in, // async reset, active high
    input wire logic lvl_in, // synchronised comparator level
    input wire logic en_in, // detection allowed this cycle
    input wire logic [1:0] mode_in, // edge_mode field
    output logic hit_out // matching edge seen
);
    logic prev_q;
    logic rise;
    logic fall;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= lvl_in;
        end
    end

    assign rise = lvl_in & ~prev_q;
    assign fall = ~lvl_in & prev_q;

    always_comb begin
        case (mode_in)
            acc_pkg::MODE_ANY: hit_out = en_in & (rise | fall);
            acc_pkg::MODE_FALL: hit_out = en_in & fall;
            acc_pkg::MODE_RISE: hit_out = en_in & rise;
            default: hit_out = 1'b0;
        endcase
    end

    a_rsvd_no_edge: assert property (@(posedge clk_in)
        disable iff (rst_in) (mode_in == acc_pkg::MODE_RSVD) |-> !hit_out)
        else $error("edge reported in reserved mode");
endmodule : acc_edge

// ==== design/acc_top.sv ====
// analog comparator control: registers, sleep gating, edge flag
// assumes AHB-Lite master, analog core result as async level
`timescale 1ns/1ps
module acc_top (
    input wire logic CLK_IN, // peripheral clock
    input wire logic SYS_RST_IN, // async reset, active high
    input wire logic HSEL_IN, // AHB slave select
    input wire logic [31:0] HADDR_IN, // AHB address
    input wire logic [1:0] HTRANS_IN, // AHB transfer type
    input wire logic HWRITE_IN, // AHB write
    input wire logic [2:0] HSIZE_IN, // AHB size, word only
    input wire logic [31:0] HWDATA_IN, // AHB write data
    input wire logic HREADY_IN, // AHB bus ready
    output logic [31:0] HRDATA_OUT, // AHB read data
    output logic HREADYOUT_OUT, // AHB slave ready
    output logic HRESP_OUT, // AHB response, always OKAY
    input wire logic CORE_RES_IN, // analog core result, async
    input wire logic [1:0] SLEEP_MODE_IN, // sleep state
    input wire logic CLK_KEEP_IN, // clock kept by another module
    output logic CORE_EN_OUT, // analog core enable
    output logic [1:0] HYST_SEL_OUT, // hysteresis select
    output logic LOW_POWER_OUT, // core reduced current
    output logic POS_SEL_OUT, // positive input select
    output logic [1:0] NEG_SEL_OUT, // negative input select
    output logic EVENT_OUT, // comparator event level
    output logic PIN_OUT, // output pin level
    output logic PIN_OE_OUT, // output pin drive enable
    output logic IRQ_OUT // interrupt request
);
    acc_pkg::acc_bus_e bus_q;
    acc_pkg::acc_bus_e bus_d;
    logic [7:0] addr_q;
    logic hready_q;
    logic hresp_q;
    logic [31:0] hrdata_q;
    logic [7:0] rd_byte;
    logic [7:0] ctrl_q;
    logic invert_q;
    logic [1:0] neg_sel_q;
    logic ie_q;
    logic flag_q;
    logic flag_d;
    logic state_q;
    logic irq_q;
    logic core_en_q;
    logic [1:0] hyst_q;
    logic lp_q;
    logic pos_q;
    logic [1:0] neg_q;
    logic event_q;
    logic pin_q;
    logic pin_oe_q;
    logic res_sync;
    logic res_lvl;
    logic hit;
    logic addr_ph;
    logic wr_en;
    logic flag_clr;
    logic enable;
    logic out_en;
    logic run_stby;
    logic run;
    logic stat_upd;

    // register bus
    assign addr_ph = HSEL_IN & HTRANS_IN[acc_pkg::HTRANS_ACT_BIT] & HREADY_IN;
    assign wr_en = (bus_q == acc_pkg::ACC_BUS_WR) & HREADY_IN;

    always_comb begin
        case (bus_q)
            acc_pkg::ACC_BUS_RDW: begin
                bus_d = acc_pkg::ACC_BUS_RDD;
            end
            default: begin
                if (addr_ph && HWRITE_IN) begin
                    bus_d = acc_pkg::ACC_BUS_WR;
                end else if (addr_ph) begin
                    bus_d = acc_pkg::ACC_BUS_RDW;
                end else begin
                    bus_d = acc_pkg::ACC_BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            bus_q <= acc_pkg::ACC_BUS_IDLE;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            bus_q <= bus_d;
            // one wait state on reads keeps read data registered
            hready_q <= (bus_d != acc_pkg::ACC_BUS_RDW);
            hresp_q <= 1'b0;
            if (addr_ph) begin
                addr_q <= HADDR_IN[7:0];
            end
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (addr_q)
            acc_pkg::ADDR_CTRL: begin
                rd_byte = ctrl_q;
            end
            acc_pkg::ADDR_MUX: begin
                rd_byte[acc_pkg::MUX_INV_BIT] = invert_q;
                rd_byte[acc_pkg::MUX_NEG_LSB +: 2] = neg_sel_q;
            end
            acc_pkg::ADDR_IE: begin
                rd_byte[acc_pkg::IE_BIT] = ie_q;
            end
            acc_pkg::ADDR_STAT: begin
                rd_byte[acc_pkg::STAT_STATE_BIT] = state_q;
                rd_byte[acc_pkg::STAT_FLAG_BIT] = flag_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            hrdata_q <= 32'h00000000;
        end else if (bus_q == acc_pkg::ACC_BUS_RDW) begin
            hrdata_q <= {24'h000000, rd_byte};
        end
    end

    // software registers, all on the peripheral clock
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            ctrl_q <= acc_pkg::RST_CTRL;
            invert_q <= acc_pkg::RST_INV;
            neg_sel_q <= acc_pkg::RST_NEG;
            ie_q <= acc_pkg::RST_IE;
        end else if (wr_en) begin
            if (addr_q == acc_pkg::ADDR_CTRL) begin
                ctrl_q <= HWDATA_IN[7:0];
            end
            if (addr_q == acc_pkg::ADDR_MUX) begin
                invert_q <= HWDATA_IN[acc_pkg::MUX_INV_BIT];
                neg_sel_q <= HWDATA_IN[acc_pkg::MUX_NEG_LSB +: 2];
            end
            if (addr_q == acc_pkg::ADDR_IE) begin
                ie_q <= HWDATA_IN[acc_pkg::IE_BIT];
            end
        end
    end

    // sleep and enable gating; debug halt has no path into here
    assign enable = ctrl_q[acc_pkg::CTRL_EN_BIT];
    assign out_en = ctrl_q[acc_pkg::CTRL_PINOE_BIT];
    assign run_stby = ctrl_q[acc_pkg::CTRL_RUNSTBY_BIT];
    assign run = enable & (SLEEP_MODE_IN != acc_pkg::SLP_PDOWN)
        & ~((SLEEP_MODE_IN == acc_pkg::SLP_STBY) & ~run_stby);
    assign stat_upd = run
        & ~((SLEEP_MODE_IN == acc_pkg::SLP_STBY) & ~CLK_KEEP_IN);

    // comparator result into the clock domain, then inverted when invert_q is set
    acc_sync u_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in(CORE_RES_IN),
        .q_out(res_sync)
    );
    assign res_lvl = res_sync ^ invert_q;

    acc_edge u_edge (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .lvl_in(res_lvl),
        .en_in(stat_upd),
        .mode_in(ctrl_q[acc_pkg::CTRL_MODE_LSB +: 2]),
        .hit_out(hit)
    );

    // interrupt flag: a new edge wins over a clearing write
    assign flag_clr = wr_en & (addr_q == acc_pkg::ADDR_STAT)
        & HWDATA_IN[acc_pkg::STAT_FLAG_BIT];
    assign flag_d = hit | (flag_q & ~flag_clr);

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            flag_q <= acc_pkg::RST_FLAG;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            irq_q <= flag_q & ie_q;
        end
    end

    // state bit: two sync stages plus this register
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state_q <= acc_pkg::RST_STATE;
        end else if (stat_upd) begin
            state_q <= res_lvl;
        end else if (!run) begin
            state_q <= 1'b0;
        end
    end

    // controls toward the analog core, event and pin
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            core_en_q <= 1'b0;
            hyst_q <= 2'h0;
            lp_q <= 1'b0;
            pos_q <= acc_pkg::POS_PIN;
            neg_q <= acc_pkg::RST_NEG;
            event_q <= 1'b0;
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            core_en_q <= run;
            hyst_q <= ctrl_q[acc_pkg::CTRL_HYS_LSB +: 2];
            lp_q <= ctrl_q[acc_pkg::CTRL_LP_BIT];
            pos_q <= acc_pkg::POS_PIN;
            neg_q <= neg_sel_q;
            event_q <= run & res_lvl;
            pin_q <= run & out_en & res_lvl;
            pin_oe_q <= run & out_en;
        end
    end

    assign HRDATA_OUT = hrdata_q;
    assign HREADYOUT_OUT = hready_q;
    assign HRESP_OUT = hresp_q;
    assign CORE_EN_OUT = core_en_q;
    assign HYST_SEL_OUT = hyst_q;
    assign LOW_POWER_OUT = lp_q;
    assign POS_SEL_OUT = pos_q;
    assign NEG_SEL_OUT = neg_q;
    assign EVENT_OUT = event_q;
    assign PIN_OUT = pin_q;
    assign PIN_OE_OUT = pin_oe_q;
    assign IRQ_OUT = irq_q;

    a_flag_on_edge: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN) hit |=> flag_q)
        else $error("edge did not set flag");

    a_flag_clear_one: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN) (flag_clr && !hit) |=> !flag_q)
        else $error("writing one did not clear flag");

    a_flag_hold: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN) (!flag_clr && !hit) |=> $stable(flag_q))
        else $error("flag changed without cause");

    a_irq_request: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        ##1 (IRQ_OUT == ($past(flag_q) && $past(ie_q))))
        else $error("request does not follow flag and enable");

    a_irq_masked: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN) (!ie_q [*2]) |-> !IRQ_OUT)
        else $error("request while disabled");

    a_state_delay: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        ($past(stat_upd) && $past(stat_upd, 3) && !$rose(SYS_RST_IN))
        |-> (state_q == ($past(CORE_RES_IN, 3) ^ $past(invert_q))))
        else $error("state bit not three cycles behind");

    a_pdown_off: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN) (SLEEP_MODE_IN == acc_pkg::SLP_PDOWN)
        |=> (!CORE_EN_OUT && !PIN_OE_OUT && !EVENT_OUT))
        else $error("active in power-down");

    a_stby_halt: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        (SLEEP_MODE_IN == acc_pkg::SLP_STBY && !run_stby) |=> !CORE_EN_OUT)
        else $error("running in standby without permission");

    a_event_follow: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        run |=> (EVENT_OUT == ($past(res_sync) ^ $past(invert_q))))
        else $error("event does not follow comparator");

    a_pin_drive: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        (run && out_en) |=> (PIN_OE_OUT && (PIN_OUT == EVENT_OUT)))
        else $error("pin not driven with comparator level");

    a_hyst_fwd: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        ##1 (HYST_SEL_OUT == $past(ctrl_q[acc_pkg::CTRL_HYS_LSB +: 2])))
        else $error("hysteresis not forwarded");

    a_read_wait: assert property (@(posedge CLK_IN)
        disable iff (SYS_RST_IN)
        (addr_ph && !HWRITE_IN) |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
        else $error("read wait state wrong");
endmodule : acc_top

// ==== test/acc_core_model.sv ====
// analog comparator core model: input muxes and the comparison
// assumes millivolt levels from the bench, controls from the block
`timescale 1ns/1ps
module acc_core_model (
    input wire logic en_in, // core enable
    input wire logic lp_in, // reduced current
    input wire logic pos_sel_in, // positive select
    input wire logic [1:0] neg_sel_in, // negative select
    input wire logic [15:0] pos_mv_in, // positive pin level
    input wire logic [15:0] neg_mv_in, // negative pin level
    input wire logic [15:0] vref_mv_in, // reference level
    input wire logic [15:0] dac_mv_in, // converter output level
    output logic raw_out // comparator result
);
    logic [15:0] neg_mv;
    logic res = 1'b0;
    // pins read as pure analog levels, digital buffers off
    always_comb begin
        case (neg_sel_in)
            acc_pkg::NEG_PIN: neg_mv = neg_mv_in;
            acc_pkg::NEG_VREF: neg_mv = vref_mv_in;
            acc_pkg::NEG_DAC: neg_mv = dac_mv_in;
            default: neg_mv = pos_mv_in;
        endcase
    end
    // an idle core toggles its result on each change of an input it watches
    always @(en_in or pos_mv_in or neg_mv or pos_sel_in) begin
        if (en_in && pos_sel_in === acc_pkg::POS_PIN) begin
            res = pos_mv_in > neg_mv;
        end else if (!en_in) begin
            res = !res;
        end
    end
    // reduced current means a slower answer
    always @(res) begin
        raw_out <= #(lp_in ? 25 : 5) res;
    end
endmodule : acc_core_model

// ==== test/acc_top_tb_top.sv ====
// self-checking bench for the analog comparator control block
// assumes acc_pkg and the core model are compiled first
`timescale 1ns/1ps
module acc_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdata;
    logic hrdy, hresp, raw, core_en, lp, pos_sel, evt, pin, pin_oe, irq;
    logic [1:0] hys, neg_sel;
    logic [1:0] slp = acc_pkg::SLP_ACTIVE;
    logic keep = 1'b0;
    logic [15:0] pos_mv = 16'h0;
    int checked = 0;
    int n_fail = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    acc_top i_acc_top (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
        .HRDATA_OUT(rdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
        .CORE_RES_IN(raw), .SLEEP_MODE_IN(slp), .CLK_KEEP_IN(keep),
        .CORE_EN_OUT(core_en), .HYST_SEL_OUT(hys), .LOW_POWER_OUT(lp),
        .POS_SEL_OUT(pos_sel), .NEG_SEL_OUT(neg_sel), .EVENT_OUT(evt),
        .PIN_OUT(pin), .PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));

    acc_core_model i_acc_core_model (.en_in(core_en), .lp_in(lp),
        .pos_sel_in(pos_sel), .neg_sel_in(neg_sel), .pos_mv_in(pos_mv),
        .neg_mv_in(16'd500), .vref_mv_in(16'd300), .dac_mv_in(16'd700),
        .raw_out(raw));

    task automatic stop_test();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hrdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            stop_test();
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        if (wr) begin
            hwdata <= {24'h0, d};
        end
        wait_rdy();
        q = rdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        cyc(2);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
        chk(32'(hresp), 32'h0);
    endtask : rd

    task automatic setv(input logic [15:0] v);
        pos_mv <= v;
        cyc(10);
    endtask : setv

    task automatic t_reset();
        rd(acc_pkg::ADDR_CTRL, 8'h00);
        rd(acc_pkg::ADDR_MUX, 8'h00);
        rd(acc_pkg::ADDR_IE, 8'h00);
        rd(acc_pkg::ADDR_STAT, 8'h00);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_config();
        logic [3:0] st;
        st = 4'b0101;
        pos_mv <= 16'd600;
        wr(acc_pkg::ADDR_CTRL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(acc_pkg::ADDR_MUX, 8'(i));
            cyc(10);
            chk(32'(neg_sel), 32'(i[1:0]));
            chk(32'(pos_sel), 32'(acc_pkg::POS_PIN));
            wr(acc_pkg::ADDR_STAT, 8'h01);
            rd(acc_pkg::ADDR_STAT, {3'h0, st[i], 4'h0});
        end
        wr(acc_pkg::ADDR_MUX, 8'hFF);
        rd(acc_pkg::ADDR_MUX, 8'h83);
        for (int h = 0; h < 4; h++) begin
            wr(acc_pkg::ADDR_CTRL, {4'b0100, h[0], h[1:0], 1'b1});
            chk(32'(hys), 32'(h[1:0]));
            chk(32'(lp), 32'(h[0]));
            chk(32'(pin_oe), 32'h1);
            rd(acc_pkg::ADDR_CTRL, {4'b0100, h[0], h[1:0], 1'b1});
        end
        $display("test config done");
    endtask : t_config

    task automatic t_edges();
        logic [1:0] md [4];
        logic [3:0] er;
        logic [3:0] ef;
        md = '{acc_pkg::MODE_ANY, acc_pkg::MODE_FALL, acc_pkg::MODE_RISE,
               acc_pkg::MODE_RSVD};
        er = 4'b0101;
        ef = 4'b0011;
        wr(acc_pkg::ADDR_MUX, 8'h00);
        wr(acc_pkg::ADDR_IE, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(acc_pkg::ADDR_CTRL, {2'b01, md[i], 4'b0001});
            setv(16'd0);
            wr(acc_pkg::ADDR_STAT, 8'h01);
            pos_mv <= 16'd1000;
            cyc(2);
            chk(32'(evt), 32'h0);
            cyc(10);
            chk(32'(evt), 32'h1);
            chk(32'(pin), 32'h1);
            rd(acc_pkg::ADDR_STAT, {7'h08, er[i]});
            chk(32'(irq), 32'(er[i]));
            wr(acc_pkg::ADDR_STAT, 8'h00);
            rd(acc_pkg::ADDR_STAT, {7'h08, er[i]});
            wr(acc_pkg::ADDR_STAT, 8'h01);
            rd(acc_pkg::ADDR_STAT, 8'h10);
            setv(16'd0);
            rd(acc_pkg::ADDR_STAT, {7'h00, ef[i]});
            wr(acc_pkg::ADDR_STAT, 8'h01);
        end
        wr(acc_pkg::ADDR_IE, 8'h00);
        wr(acc_pkg::ADDR_CTRL, 8'h41);
        setv(16'd1000);
        rd(acc_pkg::ADDR_STAT, 8'h11);
        chk(32'(irq), 32'h0);
        wr(acc_pkg::ADDR_IE, 8'h01);
        chk(32'(irq), 32'h1);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        chk(32'(irq), 32'h0);
        $display("test edges done");
    endtask : t_edges

    task automatic t_invert();
        wr(acc_pkg::ADDR_CTRL, {2'b01, acc_pkg::MODE_RISE, 4'b0001});
        setv(16'd1000);
        wr(acc_pkg::ADDR_MUX, 8'h80);
        cyc(5);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        chk(32'(evt), 32'h0);
        chk(32'(pin), 32'h0);
        rd(acc_pkg::ADDR_STAT, 8'h00);
        setv(16'd0);
        rd(acc_pkg::ADDR_STAT, 8'h11);
        wr(acc_pkg::ADDR_MUX, 8'h00);
        cyc(5);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        $display("test invert done");
    endtask : t_invert

    task automatic t_sleep();
        wr(acc_pkg::ADDR_CTRL, 8'h41);
        setv(16'd0);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        slp <= acc_pkg::SLP_IDLE;
        setv(16'd1000);
        rd(acc_pkg::ADDR_STAT, 8'h11);
        chk(32'(evt), 32'h1);
        slp <= acc_pkg::SLP_PDOWN;
        cyc(3);
        chk(32'(core_en), 32'h0);
        chk(32'(pin_oe), 32'h0);
        slp <= acc_pkg::SLP_STBY;
        cyc(3);
        chk(32'(core_en), 32'h0);
        slp <= acc_pkg::SLP_ACTIVE;
        wr(acc_pkg::ADDR_CTRL, 8'hC1);
        setv(16'd0);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        slp <= acc_pkg::SLP_STBY;
        cyc(3);
        chk(32'(core_en), 32'h1);
        setv(16'd1000);
        chk(32'(evt), 32'h1);
        chk(32'(pin), 32'h1);
        rd(acc_pkg::ADDR_STAT, 8'h00);
        keep <= 1'b1;
        setv(16'd0);
        rd(acc_pkg::ADDR_STAT, 8'h01);
        keep <= 1'b0;
        slp <= acc_pkg::SLP_ACTIVE;
        cyc(5);
        wr(acc_pkg::ADDR_STAT, 8'h01);
        $display("test sleep done");
    endtask : t_sleep

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_config();
        t_edges();
        t_invert();
        t_sleep();
        stop_test();
    end
endmodule : acc_top_tb_top
